// ### hw/pwr_seq_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz system clock, 32-bit AXI4-Lite register words
// Notes: Included by the package users and the main module
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH

`define CLK_HZ 50000000
`define TICK_US 1
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_US)

`define OFF_CTRL 8'h00
`define OFF_IDLE_PER 8'h04
`define OFF_SLEEP_PER 8'h08
`define OFF_DEEP_PER 8'h0C
`define OFF_WAKE_PER 8'h10
`define OFF_STATUS 8'h14
`define OFF_IRQ_STAT 8'h18
`define OFF_IRQ_MASK 8'h1C

`define CTRL_AUTO_BIT 0
`define CTRL_TIMED_BIT 1
`define CTRL_REG_EN_BIT 2
`define CTRL_FORCE_WAKE_BIT 3
`define CTRL_FORCE_DEEP_BIT 4

`define IRQ_STEP_BIT 0
`define IRQ_WAKE_BIT 1
`define IRQ_TIMED_BIT 2
`define IRQ_W 3

`define CTRL_RESET 32'h0000_0005
`define IDLE_PER_RESET 32'h0000_03E8
`define SLEEP_PER_RESET 32'h0000_2710
`define DEEP_PER_RESET 32'h0001_86A0
`define WAKE_PER_RESET 32'h000F_4240

`endif

// ### hw/pwr_seq_pkg.sv
// Purpose: Types shared by the power sequencer files
// Assumes: Nothing beyond the cfg header
// Notes: Gray codes along active-idle-sleep-deep path
package pwr_seq_pkg;
  typedef enum logic [2:0] {
    PM_ACTIVE = 3'h0,
    PM_IDLE = 3'h1,
    PM_SLEEP = 3'h3,
    PM_DEEP = 3'h2,
    PM_TIMED_DEEP = 3'h6
  } pwr_state_t;
endpackage : pwr_seq_pkg

// ### hw/aon_wake_watch.sv
// Purpose: Always-on watch logic that keeps a wake timer in deep power-off
// Assumes: Tick is a one-cycle enable pulse
// Notes: Stays powered while the core regulator output is off
`timescale 1ns/1ps
module aon_wake_watch #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic deep_active,
  input wire logic timed,
  input wire logic [WIDTH-1:0] wake_period,
  input wire logic user_event,
  output logic wake_event,
  output logic wake_timed
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic wake_reg;
  logic wake_next;
  logic timed_reg;
  logic timed_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    wake_next = 1'b0;
    timed_next = 1'b0;
    if (!deep_active)
    begin
      cnt_next = '0;
    end
    else if (user_event)
    begin
      wake_next = 1'b1;
    end
    else if (timed && tick)
    begin
      if (cnt_reg + 1'b1 >= wake_period)
      begin
        wake_next = 1'b1;
        timed_next = 1'b1;
        cnt_next = '0;
      end
      else
      begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      wake_reg <= 1'b0;
      timed_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      wake_reg <= wake_next;
      timed_reg <= timed_next;
    end
  end

  assign wake_event = wake_reg;
  assign wake_timed = timed_reg;
endmodule : aon_wake_watch

// ### hw/power_mode_sequencer.sv
// Purpose: Power-mode sequencer with radio power-down controls
// Assumes: AXI4-Lite slave, one 50 MHz clock, periods in microsecond ticks
// Notes: Our own design choices follow
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "pwr_seq_cfg.svh"
module power_mode_sequencer #(
  parameter int PER_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic user_activity,
  input wire logic bb_tx_req,
  input wire logic bb_rx_req,
  output logic tx_pd,
  output logic rx_pd,
  output logic pll_pd,
  output logic pa_pd,
  output logic core_regulator_output,
  output logic [2:0] pwr_state,
  output logic irq
);
  import pwr_seq_pkg::*;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] idle_per_reg, idle_per_next;
  logic [31:0] sleep_per_reg, sleep_per_next;
  logic [31:0] deep_per_reg, deep_per_next;
  logic [31:0] wake_per_reg, wake_per_next;
  logic [`IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [`IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic irq_reg, irq_next;
  pwr_state_t st_reg, st_next;
  logic [PER_W-1:0] idle_cnt_reg, idle_cnt_next;
  logic [5:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  logic [3:0] pd_reg, pd_next;
  logic ldo_reg, ldo_next;
  logic wake_event, wake_timed;
  logic do_write, do_read, force_wake, step_evt, activity;
  logic [PER_W-1:0] cur_period;

  assign tick = (tick_cnt_reg == 6'(`TICK_CYCLES - 1));
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign do_read = s_axi_arvalid && !rvalid_reg;
  assign force_wake = do_write && aw_addr_reg == `OFF_CTRL && w_strb_reg[0]
                      && w_data_reg[`CTRL_FORCE_WAKE_BIT];
  assign activity = user_activity || bb_tx_req || bb_rx_req || force_wake;

  always_comb
  begin
    case (st_reg)
      PM_ACTIVE: cur_period = PER_W'(idle_per_reg);
      PM_IDLE: cur_period = PER_W'(sleep_per_reg);
      PM_SLEEP: cur_period = PER_W'(deep_per_reg);
      default: cur_period = '1;
    endcase
  end

  // Bus slave: address and data taken in either order
  always_comb
  begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    ctrl_next = ctrl_reg;
    idle_per_next = idle_per_reg;
    sleep_per_next = sleep_per_reg;
    deep_per_next = deep_per_reg;
    wake_per_next = wake_per_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (s_axi_awvalid && !aw_full_reg)
    begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_reg)
    begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = 2'h0;
      case (aw_addr_reg)
        `OFF_CTRL: ctrl_next = wmerge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_0007;
        `OFF_IDLE_PER: idle_per_next = wmerge(idle_per_reg, w_data_reg, w_strb_reg);
        `OFF_SLEEP_PER: sleep_per_next = wmerge(sleep_per_reg, w_data_reg, w_strb_reg);
        `OFF_DEEP_PER: deep_per_next = wmerge(deep_per_reg, w_data_reg, w_strb_reg);
        `OFF_WAKE_PER: wake_per_next = wmerge(wake_per_reg, w_data_reg, w_strb_reg);
        `OFF_IRQ_MASK: irq_mask_next = 3'(wmerge({29'h0, irq_mask_reg}, w_data_reg,
                                                 w_strb_reg));
        `OFF_STATUS, `OFF_IRQ_STAT: bresp_next = 2'h0;
        default: bresp_next = 2'h2;
      endcase
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
    if (do_read)
    begin
      rvalid_next = 1'b1;
      rresp_next = 2'h0;
      case (s_axi_araddr)
        `OFF_CTRL: rdata_next = ctrl_reg;
        `OFF_IDLE_PER: rdata_next = idle_per_reg;
        `OFF_SLEEP_PER: rdata_next = sleep_per_reg;
        `OFF_DEEP_PER: rdata_next = deep_per_reg;
        `OFF_WAKE_PER: rdata_next = wake_per_reg;
        `OFF_STATUS: rdata_next = {23'h0, ldo_reg, pd_reg, 1'b0, st_reg};
        `OFF_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
        `OFF_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
        default:
        begin
          rdata_next = 32'h0000_0000;
          rresp_next = 2'h2;
        end
      endcase
      if (s_axi_araddr == `OFF_IRQ_STAT)
      begin
        irq_stat_next = '0;
      end
    end
    // Set wins over the read clear
    if (step_evt)
    begin
      irq_stat_next[`IRQ_STEP_BIT] = 1'b1;
    end
    if (wake_event)
    begin
      irq_stat_next[`IRQ_WAKE_BIT] = 1'b1;
    end
    if (wake_timed)
    begin
      irq_stat_next[`IRQ_TIMED_BIT] = 1'b1;
    end
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  // Power state walk
  always_comb
  begin
    st_next = st_reg;
    idle_cnt_next = idle_cnt_reg;
    tick_cnt_next = tick ? 6'h00 : tick_cnt_reg + 6'h01;
    step_evt = 1'b0;
    if (st_reg == PM_DEEP || st_reg == PM_TIMED_DEEP)
    begin
      if (wake_event)
      begin
        st_next = PM_ACTIVE;
        idle_cnt_next = '0;
      end
    end
    else if (activity)
    begin
      st_next = PM_ACTIVE;
      idle_cnt_next = '0;
    end
    else if (ctrl_reg[`CTRL_AUTO_BIT] && tick)
    begin
      if (idle_cnt_reg + 1'b1 >= cur_period)
      begin
        idle_cnt_next = '0;
        step_evt = 1'b1;
        case (st_reg)
          PM_ACTIVE: st_next = PM_IDLE;
          PM_IDLE: st_next = PM_SLEEP;
          PM_SLEEP: st_next = ctrl_reg[`CTRL_TIMED_BIT] ? PM_TIMED_DEEP : PM_DEEP;
          default: st_next = st_reg;
        endcase
      end
      else
      begin
        idle_cnt_next = idle_cnt_reg + 1'b1;
      end
    end
    if (do_write && aw_addr_reg == `OFF_CTRL && w_strb_reg[0]
        && w_data_reg[`CTRL_FORCE_DEEP_BIT] && !activity)
    begin
      st_next = ctrl_reg[`CTRL_TIMED_BIT] ? PM_TIMED_DEEP : PM_DEEP;
      step_evt = 1'b1;
    end
  end

  // Radio and regulator controls: pd bits are tx, rx, pll, pa
  always_comb
  begin
    pd_next = 4'hF;
    if (st_next == PM_ACTIVE)
    begin
      pd_next[0] = !bb_tx_req;
      pd_next[1] = !bb_rx_req;
      pd_next[2] = !(bb_tx_req || bb_rx_req);
      pd_next[3] = !bb_tx_req;
    end
    // Only shut regulator when firmware allows it; follows the enable write at once
    ldo_next = !((st_next == PM_DEEP || st_next == PM_TIMED_DEEP)
                 && ctrl_next[`CTRL_REG_EN_BIT]);
  end

  aon_wake_watch #(
    .WIDTH(32)
  ) u_aon (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .deep_active(st_reg == PM_DEEP || st_reg == PM_TIMED_DEEP),
    .timed(st_reg == PM_TIMED_DEEP),
    .wake_period(wake_per_reg),
    .user_event(user_activity),
    .wake_event(wake_event),
    .wake_timed(wake_timed)
  );

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
      ctrl_reg <= `CTRL_RESET;
      idle_per_reg <= `IDLE_PER_RESET;
      sleep_per_reg <= `SLEEP_PER_RESET;
      deep_per_reg <= `DEEP_PER_RESET;
      wake_per_reg <= `WAKE_PER_RESET;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
      st_reg <= PM_ACTIVE;
      idle_cnt_reg <= '0;
      tick_cnt_reg <= 6'h00;
      pd_reg <= 4'hF;
      ldo_reg <= 1'b1;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ctrl_reg <= ctrl_next;
      idle_per_reg <= idle_per_next;
      sleep_per_reg <= sleep_per_next;
      deep_per_reg <= deep_per_next;
      wake_per_reg <= wake_per_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
      st_reg <= st_next;
      idle_cnt_reg <= idle_cnt_next;
      tick_cnt_reg <= tick_cnt_next;
      pd_reg <= pd_next;
      ldo_reg <= ldo_next;
    end
  end

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign {pa_pd, pll_pd, rx_pd, tx_pd} = pd_reg;
  assign core_regulator_output = ldo_reg;
  assign pwr_state = st_reg;
  assign irq = irq_reg;

  chk_wake_active: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (user_activity && st_reg != PM_DEEP && st_reg != PM_TIMED_DEEP) |=> st_reg == PM_ACTIVE)
    else $error("activity did not return to active");
  chk_deep_ldo: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_reg == PM_DEEP && ctrl_reg[`CTRL_REG_EN_BIT]) |-> !core_regulator_output)
    else $error("regulator on in deep power-off");
  chk_ldo_fw: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_reg[`CTRL_REG_EN_BIT] && $stable(ctrl_reg) |-> core_regulator_output)
    else $error("regulator off without firmware enable");
  chk_aon_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_reg == PM_DEEP && user_activity) |-> ##2 st_reg == PM_ACTIVE)
    else $error("deep off missed user event");
  chk_step_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_reg == PM_ACTIVE ##1 st_reg != PM_ACTIVE) |-> st_reg == PM_IDLE
      || st_reg == PM_DEEP || st_reg == PM_TIMED_DEEP)
    else $error("bad step from active");
  chk_tx_pd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_reg != PM_ACTIVE) |-> tx_pd && rx_pd && pll_pd && pa_pd)
    else $error("radio on outside active");
  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq == |(irq_stat_reg & irq_mask_reg))
    else $error("irq mismatch");
  chk_wake_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wake_event |=> irq_stat_reg[`IRQ_WAKE_BIT])
    else $error("wake event not flagged");
  chk_timed_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wake_timed |=> st_reg == PM_ACTIVE)
    else $error("timed wake did not restore");
endmodule : power_mode_sequencer

// ### dv/radio_far_side.sv
// Purpose: Far-side model of radio power controls and wake source
// Assumes: Bench commands arrive as levels after a clock edge
// Notes: A radio path is live only while core power is on
`timescale 1ns/1ps
module radio_far_side (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tx_go,
  input wire logic rx_go,
  input wire logic wake_go,
  input wire logic tx_pd,
  input wire logic rx_pd,
  input wire logic pll_pd,
  input wire logic pa_pd,
  input wire logic core_regulator_output,
  output logic bb_tx_req,
  output logic bb_rx_req,
  output logic user_activity,
  output logic tx_live,
  output logic rx_live
);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bb_tx_req <= 1'b0;
      bb_rx_req <= 1'b0;
      user_activity <= 1'b0;
    end
    else
    begin
      bb_tx_req <= tx_go;
      bb_rx_req <= rx_go;
      user_activity <= wake_go;
    end
  end
  // Transmit needs synthesizer and amplifier too
  assign tx_live = core_regulator_output & ~tx_pd & ~pll_pd & ~pa_pd;
  assign rx_live = core_regulator_output & ~rx_pd & ~pll_pd;
endmodule : radio_far_side

// ### dv/power_mode_sequencer_tb_top.sv
// Purpose: Register-driven test of the power-mode sequencer
// Assumes: Periods shortened to 3 ticks of 50 cycles
// Notes: Stops at first hung wait
`timescale 1ns/1ps
`include "pwr_seq_cfg.svh"
module power_mode_sequencer_tb_top;
  import pwr_seq_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic [1:0] s_axi_bresp;
  logic s_axi_wready;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic user_activity, bb_tx_req, bb_rx_req, tx_pd, rx_pd, pll_pd, pa_pd;
  logic core_regulator_output, irq, tx_live, rx_live;
  logic [2:0] pwr_state;
  logic tx_go = 1'b0;
  logic rx_go = 1'b0;
  logic wake_go = 1'b0;
  logic forcing = 1'b0;
  logic [2:0] prev_st = 3'h0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [31:0] rv [5] = '{`CTRL_RESET, `IDLE_PER_RESET, `SLEEP_PER_RESET,
    `DEEP_PER_RESET, `WAKE_PER_RESET};
  int miscompares = 0;
  int n_tests = 0;
  int k;

  always #10 sys_clk = ~sys_clk;

  power_mode_sequencer #(.PER_W(32)) dut_u (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .user_activity, .bb_tx_req,
    .bb_rx_req, .tx_pd, .rx_pd, .pll_pd, .pa_pd, .core_regulator_output, .pwr_state, .irq);

  radio_far_side far_u (.sys_clk, .rst_n, .tx_go, .rx_go, .wake_go, .tx_pd, .rx_pd, .pll_pd,
    .pa_pd, .core_regulator_output, .bb_tx_req, .bb_rx_req, .user_activity, .tx_live,
    .rx_live);

  task finish_test;
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task give_up;
    miscompares++;
    $display("BAD %0t wait ran out", $time);
    finish_test();
  endtask : give_up

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    if (i == 50)
      give_up();
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : axw

  task axr(input logic [7:0] a);
    int i;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    if (i == 50)
      give_up();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task wst(input pwr_state_t s, input int n);
    int i;
    for (i = 0; i < n && pwr_state !== s; i++)
      @(posedge sys_clk);
    if (pwr_state !== s)
      give_up();
    chk(32'(pwr_state), 32'(s));
  endtask : wst

  function automatic logic step_ok(input logic [2:0] a, input logic [2:0] b);
    return (a == PM_ACTIVE && b == PM_IDLE) || (a == PM_IDLE && b == PM_SLEEP) ||
      (a == PM_SLEEP && (b == PM_DEEP || b == PM_TIMED_DEEP));
  endfunction : step_ok

  // Every downward move, forced ones aside, must be one step along the order
  always @(posedge sys_clk)
  begin
    if (rst_n && pwr_state !== prev_st && pwr_state !== PM_ACTIVE && !forcing)
      chk(32'(step_ok(prev_st, pwr_state)), 32'h1);
    prev_st <= pwr_state;
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 5; k++)
    begin
      axr(8'(4 * k));
      chk(rd, rv[k]);
    end
    axr(`OFF_STATUS);
    chk(rd, 32'h0000_01F0);
    axr(8'h20);
    chk(32'(rsp), 32'h2);
    chk(rd, 32'h0);
    axw(`OFF_STATUS, 32'h0000_0000, 2'h0);
    axr(`OFF_STATUS);
    chk(rd, 32'h0000_01F0);
    for (k = 1; k < 5; k++)
      axw(8'(4 * k), 32'h0000_0003, 2'h0);
    axw(`OFF_IRQ_MASK, 32'h0000_0007, 2'h0);
    axw(`OFF_CTRL, 32'h0000_0005, 2'h0);
    wst(PM_IDLE, 1000);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    axr(`OFF_IRQ_STAT);
    chk(rd & 32'h1, 32'h1);
    wst(PM_SLEEP, 1000);
    wst(PM_DEEP, 1000);
    repeat (3) @(posedge sys_clk);
    chk(32'(core_regulator_output), 32'h0);
    wake_go <= 1'b1;
    wst(PM_ACTIVE, 6);
    chk(32'(core_regulator_output), 32'h1);
    wake_go <= 1'b0;
    wst(PM_SLEEP, 1000);
    tx_go <= 1'b1;
    wst(PM_ACTIVE, 6);
    repeat (4) @(posedge sys_clk);
    chk(32'({tx_live, rx_live}), 32'h2);
    tx_go <= 1'b0;
    rx_go <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(32'({tx_live, rx_live}), 32'h1);
    rx_go <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(32'({tx_live, rx_live}), 32'h0);
    axw(`OFF_CTRL, 32'h0000_0007, 2'h0);
    wst(PM_TIMED_DEEP, 1000);
    repeat (3) @(posedge sys_clk);
    chk(32'(core_regulator_output), 32'h0);
    wst(PM_ACTIVE, 400);
    axr(`OFF_IRQ_STAT);
    chk(rd & 32'h4, 32'h4);
    axw(`OFF_IRQ_MASK, 32'h0000_0000, 2'h0);
    axw(`OFF_CTRL, 32'h0000_0001, 2'h0);
    wst(PM_DEEP, 2000);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    chk(32'(core_regulator_output), 32'h1);
    wake_go <= 1'b1;
    wst(PM_ACTIVE, 6);
    wake_go <= 1'b0;
    wst(PM_IDLE, 1000);
    axw(`OFF_CTRL, 32'h0000_0009, 2'h0);
    wst(PM_ACTIVE, 6);
    forcing <= 1'b1;
    axw(`OFF_CTRL, 32'h0000_0015, 2'h0);
    wst(PM_DEEP, 6);
    repeat (3) @(posedge sys_clk);
    chk(32'(core_regulator_output), 32'h0);
    wake_go <= 1'b1;
    wst(PM_ACTIVE, 6);
    wake_go <= 1'b0;
    forcing <= 1'b0;
    finish_test();
  end
endmodule : power_mode_sequencer_tb_top
